// ### core/asm_ctrl.sv
// cipher security module: serial sram access, control, status and 128-bit cipher core
//
// Summary of operation
// - a write burst ending with start bit set at the mirror starts an operation
// - mirror address reads and writes the same control fields as the control register
// - status ready bit 0 reads 0 while busy, 1 after the fixed processing time
// - window writes the key store and reads the round key in key mode, else the data block
// - only sram read and write commands reach these registers
// - sleep returns every register, key and data included, to reset
// - status bit 7 flags control access while busy or a short data read
// - any control access while busy aborts the running operation
// - writing one to control bit 7 launches an operation in codebook or chaining mode; reads 0 when idle
// - mode bits 6..4: 0 codebook, 1 key load, 2 chaining, 3..7 reserved
// - control bit 3: 0 encrypt, 1 decrypt; bits 2..0 reserved
// - status is read only; bits 6..1 read zero
// - chaining mode xors previous result with the new block before encryption
// - key window reads the last round key after encrypting, the first after decrypting; the written key stays for next run
// - during writes the old content of each byte shifts out one byte later
`timescale 1ns/1ns
`default_nettype none
module asm_ctrl
  import asm_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // transceiver sleep state
  input wire logic sleep_i,
  // serial host port
  input wire logic spi_sel_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o
);

  function automatic logic [7:0] xt(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
  endfunction

  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] r;
    logic [7:0] p;
    r = 8'h00;
    p = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) r = r ^ p;
      p = xt(p);
    end
    return r;
  endfunction

  // x^254 is the field inverse and maps zero to zero, so no table is needed
  function automatic logic [7:0] ginv(input logic [7:0] x);
    logic [7:0] r;
    logic [7:0] p;
    r = 8'h01;
    p = x;
    for (int i = 1; i < 8; i++) begin
      p = gmul(p, p);
      r = gmul(r, p);
    end
    return r;
  endfunction

  function automatic logic [7:0] sbox(input logic [7:0] x);
    logic [7:0] i;
    i = ginv(x);
    return i ^ {i[6:0], i[7]} ^ {i[5:0], i[7:6]} ^ {i[4:0], i[7:5]} ^ {i[3:0], i[7:4]} ^ 8'h63;
  endfunction

  function automatic logic [7:0] isbox(input logic [7:0] y);
    return ginv({y[6:0], y[7]} ^ {y[4:0], y[7:5]} ^ {y[1:0], y[7:2]} ^ 8'h05);
  endfunction

  function automatic logic [31:0] subword(input logic [31:0] w);
    return {sbox(w[31:24]), sbox(w[23:16]), sbox(w[15:8]), sbox(w[7:0])};
  endfunction

  function automatic logic [7:0] rcon(input logic [3:0] n);
    case (n)
      4'h1: return 8'h01;
      4'h2: return 8'h02;
      4'h3: return 8'h04;
      4'h4: return 8'h08;
      4'h5: return 8'h10;
      4'h6: return 8'h20;
      4'h7: return 8'h40;
      4'h8: return 8'h80;
      4'h9: return 8'h1B;
      4'hA: return 8'h36;
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [127:0] next_key(input logic [127:0] k, input logic [7:0] rc);
    logic [31:0] w0;
    logic [31:0] w1;
    logic [31:0] w2;
    logic [31:0] w3;
    w0 = k[127:96] ^ subword({k[23:0], k[31:24]}) ^ {rc, 24'h000000};
    w1 = k[95:64] ^ w0;
    w2 = k[63:32] ^ w1;
    w3 = k[31:0] ^ w2;
    return {w0, w1, w2, w3};
  endfunction

  // walks the key schedule backward, so decryption starts from the last round key
  function automatic logic [127:0] prev_key(input logic [127:0] k, input logic [7:0] rc);
    logic [31:0] p0;
    logic [31:0] p3;
    p3 = k[31:0] ^ k[63:32];
    p0 = k[127:96] ^ subword({p3[23:0], p3[31:24]}) ^ {rc, 24'h000000};
    return {p0, k[127:96] ^ k[95:64], k[95:64] ^ k[63:32], p3};
  endfunction

  // byte 4c+r sits in row r, column c; byte 0 is the top of the vector
  function automatic logic [127:0] sub_shift(input logic [127:0] s, input logic inv);
    logic [127:0] t;
    int src;
    t = '0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        src = inv ? 4 * ((c - r + 4) % 4) + r : 4 * ((c + r) % 4) + r;
        t[127 - 8 * (4 * c + r) -: 8] = inv ? isbox(s[127 - 8 * src -: 8])
                                            : sbox(s[127 - 8 * src -: 8]);
      end
    end
    return t;
  endfunction

  function automatic logic [127:0] mix(input logic [127:0] s, input logic inv);
    logic [127:0] t;
    logic [7:0] a [4];
    t = '0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) a[r] = s[127 - 8 * (4 * c + r) -: 8];
      for (int r = 0; r < 4; r++) begin
        t[127 - 8 * (4 * c + r) -: 8] = inv
          ? gmul(a[r], 8'h0E) ^ gmul(a[(r + 1) % 4], 8'h0B) ^
            gmul(a[(r + 2) % 4], 8'h0D) ^ gmul(a[(r + 3) % 4], 8'h09)
          : xt(a[r]) ^ xt(a[(r + 1) % 4]) ^ a[(r + 1) % 4] ^ a[(r + 2) % 4] ^ a[(r + 3) % 4];
      end
    end
    return t;
  endfunction

  function automatic logic is_ctrl(input logic [7:0] a);
    return (a == ADDR_CTRL) || (a == ADDR_MIRROR);
  endfunction

  function automatic logic is_win(input logic [7:0] a);
    return (a >= ADDR_WIN_LO) && (a <= ADDR_WIN_HI);
  endfunction

  // the lowest window address is the top byte of the cipher vector
  function automatic logic [6:0] win_pos(input logic [7:0] a);
    logic [3:0] idx;
    idx = a[3:0] - ADDR_WIN_LO[3:0];
    return {~idx, 3'b000};
  endfunction

  asm_spi_type pin_m_q;
  asm_spi_type pin_s_q;
  asm_spi_type pin_p_q;
  logic sleep_m_q;
  logic sleep_s_q;
  logic clr;
  logic rise;
  logic fall;
  logic burst_end;
  logic [2:0] bit_q;
  logic [7:0] rx_q;
  logic [7:0] byte_q;
  logic byte_vld_q;
  logic [7:0] tx_q;
  asm_phase_type phase_q;
  logic wr_q;
  logic rd_q;
  logic [7:0] addr_q;
  logic [7:0] sel;
  logic [7:0] rd_data;
  logic tx_load;
  logic rd_done;
  logic wr_en;
  logic ctrl_touch;
  logic start;
  logic abort;
  logic mask_err;
  logic [15:0] rd_mask_q;
  asm_ctrl_type ctrl_q;
  logic [127:0] key_q;
  logic [127:0] rk_q;
  logic [127:0] state_q;
  logic [127:0] chain_q;
  logic busy_q;
  logic ready_q;
  logic err_q;
  logic dir_q;
  logic [3:0] rnd_q;
  logic [9:0] cnt_q;
  logic [127:0] enc_key;
  logic [127:0] dec_key;
  logic last_rnd;

  // pins and sleep come from outside this clock: two flops before use
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      pin_m_q <= SPI_IDLE;
      pin_s_q <= SPI_IDLE;
      pin_p_q <= SPI_IDLE;
      sleep_m_q <= 1'b0;
      sleep_s_q <= 1'b0;
    end else begin
      pin_m_q <= {spi_sel_n_i, spi_sclk_i, spi_mosi_i};
      pin_s_q <= pin_m_q;
      pin_p_q <= pin_s_q;
      sleep_m_q <= sleep_i;
      sleep_s_q <= sleep_m_q;
    end
  end

  assign clr = !rstn_i || sleep_s_q;
  assign rise = pin_s_q.sclk && !pin_p_q.sclk && !pin_s_q.sel_n;
  assign fall = !pin_s_q.sclk && pin_p_q.sclk && !pin_s_q.sel_n;
  assign burst_end = pin_s_q.sel_n && !pin_p_q.sel_n;

  // mode 0 receive: sample on rising edge, one byte strobe per eight bits
  always_ff @(posedge clock_i) begin
    if (clr || pin_s_q.sel_n) begin
      bit_q <= 3'h0;
      rx_q <= 8'h00;
      byte_q <= 8'h00;
      byte_vld_q <= 1'b0;
    end else begin
      byte_vld_q <= 1'b0;
      if (rise) begin
        rx_q <= {rx_q[6:0], pin_s_q.mosi};
        bit_q <= bit_q + 3'h1;
        if (bit_q == BIT_LAST) begin
          byte_vld_q <= 1'b1;
          byte_q <= {rx_q[6:0], pin_s_q.mosi};
        end
      end
    end
  end

  // no shift on the fall that closes a byte, so the fresh load keeps its top bit
  always_ff @(posedge clock_i) begin
    if (clr) begin
      tx_q <= 8'h00;
    end else if (tx_load) begin
      tx_q <= rd_data;
    end else if (fall && bit_q != 3'h0) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  assign spi_miso_o = tx_q[7];
  assign spi_miso_oe_o = !pin_s_q.sel_n;

  always_ff @(posedge clock_i) begin
    if (clr || pin_s_q.sel_n) begin
      phase_q <= PH_CMD;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 8'h00;
    end else if (byte_vld_q) begin
      case (phase_q)
        PH_CMD: begin
          wr_q <= byte_q[7:6] == CMD_SRAM_WR;
          rd_q <= byte_q[7:6] == CMD_SRAM_RD;
          phase_q <= PH_ADDR;
        end
        PH_ADDR: begin
          addr_q <= byte_q;
          phase_q <= PH_DATA;
        end
        PH_DATA: addr_q <= addr_q + 8'h01;
        default: phase_q <= PH_CMD;
      endcase
    end
  end

  // reads prefetch the next byte; writes fetch the old content of the byte just written
  always_comb begin
    sel = (phase_q == PH_ADDR) ? byte_q : (rd_q ? addr_q + 8'h01 : addr_q);
    tx_load = byte_vld_q && (((phase_q == PH_ADDR) && rd_q) ||
                             ((phase_q == PH_DATA) && (rd_q || wr_q)));
    // a read counts once its byte is clocked out, so a prefetch never aborts a run
    rd_done = byte_vld_q && (phase_q == PH_DATA) && rd_q;
    wr_en = byte_vld_q && (phase_q == PH_DATA) && wr_q;
    rd_data = 8'h00;
    if (sel == ADDR_STATUS) begin
      rd_data[ERR_BIT] = err_q;
      rd_data[RDY_BIT] = ready_q;
    end else if (is_ctrl(sel)) begin
      rd_data[REQ_BIT] = busy_q;
      rd_data[MODE_HI:MODE_LO] = ctrl_q.mode;
      rd_data[DIR_BIT] = ctrl_q.dir;
    end else if (is_win(sel)) begin
      rd_data = (ctrl_q.mode == MODE_KEY) ? rk_q[win_pos(sel) +: 8]
                                          : state_q[win_pos(sel) +: 8];
    end
  end

  assign ctrl_touch = (rd_done || wr_en) && is_ctrl(addr_q);
  assign abort = ctrl_touch && busy_q;
  assign start = wr_en && is_ctrl(addr_q) && !busy_q && byte_q[REQ_BIT] &&
                 (byte_q[MODE_HI:MODE_LO] == MODE_ECB ||
                  byte_q[MODE_HI:MODE_LO] == MODE_CBC);
  assign mask_err = burst_end && rd_mask_q != 16'h0000 && rd_mask_q != WIN_ALL;

  always_ff @(posedge clock_i) begin
    if (clr) begin
      ctrl_q <= '0;
      key_q <= '0;
    end else if (wr_en && !busy_q) begin
      if (is_ctrl(addr_q)) begin
        ctrl_q <= {byte_q[MODE_HI:MODE_LO], byte_q[DIR_BIT]};
      end else if (is_win(addr_q) && ctrl_q.mode == MODE_KEY) begin
        key_q[win_pos(addr_q) +: 8] <= byte_q;
      end
    end
  end

  // error and short-read tracking; the set side wins over the clear at start
  always_ff @(posedge clock_i) begin
    if (clr) begin
      err_q <= 1'b0;
      rd_mask_q <= 16'h0000;
    end else begin
      if (abort || mask_err) begin
        err_q <= 1'b1;
      end else if (start) begin
        err_q <= 1'b0;
      end
      if (pin_s_q.sel_n) begin
        rd_mask_q <= 16'h0000;
      end else if (rd_done && is_win(addr_q) && ctrl_q.mode != MODE_KEY) begin
        rd_mask_q[addr_q[3:0]] <= 1'b1;
      end
    end
  end

  assign enc_key = next_key(rk_q, rcon(rnd_q + 4'h1));
  assign dec_key = prev_key(rk_q, rcon(ROUNDS - rnd_q));
  assign last_rnd = rnd_q == ROUNDS - 4'h1;

  // one round per clock; the ready flag waits out the full processing time
  always_ff @(posedge clock_i) begin
    if (clr) begin
      busy_q <= 1'b0;
      ready_q <= 1'b0;
      dir_q <= 1'b0;
      rnd_q <= 4'h0;
      cnt_q <= 10'h000;
      rk_q <= '0;
      state_q <= '0;
      chain_q <= '0;
    end else if (abort) begin
      busy_q <= 1'b0;
    end else if (start) begin
      busy_q <= 1'b1;
      ready_q <= 1'b0;
      dir_q <= byte_q[DIR_BIT];
      rnd_q <= 4'h0;
      cnt_q <= 10'h000;
      rk_q <= key_q;
      state_q <= ((byte_q[MODE_HI:MODE_LO] == MODE_CBC) ? state_q ^ chain_q : state_q)
                 ^ key_q;
    end else if (busy_q) begin
      cnt_q <= cnt_q + 10'h001;
      if (rnd_q != ROUNDS) begin
        rnd_q <= rnd_q + 4'h1;
        if (!dir_q) begin
          rk_q <= enc_key;
          state_q <= (last_rnd ? sub_shift(state_q, 1'b0)
                               : mix(sub_shift(state_q, 1'b0), 1'b0)) ^ enc_key;
        end else begin
          rk_q <= dec_key;
          state_q <= last_rnd ? sub_shift(state_q, 1'b1) ^ dec_key
                              : mix(sub_shift(state_q, 1'b1) ^ dec_key, 1'b1);
        end
      end
      if (cnt_q == PROC_LAST) begin
        busy_q <= 1'b0;
        ready_q <= 1'b1;
        chain_q <= state_q;
      end
    end else if (wr_en && is_win(addr_q)) begin
      if (ctrl_q.mode == MODE_KEY) begin
        rk_q[win_pos(addr_q) +: 8] <= byte_q;
      end else begin
        state_q[win_pos(addr_q) +: 8] <= byte_q;
      end
    end
  end

endmodule
`default_nettype wire

// ### core/asm_pkg.sv
// constants and types of the cipher security module control block
package asm_pkg;
  localparam logic [7:0] ADDR_STATUS = 8'h82;
  localparam logic [7:0] ADDR_CTRL = 8'h83;
  localparam logic [7:0] ADDR_WIN_LO = 8'h84;
  localparam logic [7:0] ADDR_WIN_HI = 8'h93;
  localparam logic [7:0] ADDR_MIRROR = 8'h94;
  localparam int ERR_BIT = 7;
  localparam int RDY_BIT = 0;
  localparam int REQ_BIT = 7;
  localparam int MODE_HI = 6;
  localparam int MODE_LO = 4;
  localparam int DIR_BIT = 3;
  localparam logic [2:0] MODE_ECB = 3'h0;
  localparam logic [2:0] MODE_KEY = 3'h1;
  localparam logic [2:0] MODE_CBC = 3'h2;
  localparam logic [1:0] CMD_SRAM_RD = 2'h0;
  localparam logic [1:0] CMD_SRAM_WR = 2'h1;
  localparam int CLK_PERIOD_NS = 40;
  localparam int PROC_TIME_NS = 24000;
  localparam int PROC_CYCLES = (PROC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] PROC_LAST = 10'(PROC_CYCLES - 1);
  localparam logic [3:0] ROUNDS = 4'hA;
  localparam logic [15:0] WIN_ALL = 16'hFFFF;
  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef struct packed {
    logic [2:0] mode;
    logic dir;
  } asm_ctrl_type;

  typedef struct packed {
    logic sel_n;
    logic sclk;
    logic mosi;
  } asm_spi_type;

  localparam asm_spi_type SPI_IDLE = 3'h4;

  typedef enum logic [2:0] {
    PH_CMD = 3'b001,
    PH_ADDR = 3'b010,
    PH_DATA = 3'b100
  } asm_phase_type;
endpackage

// ### tb/asm_ctrl_chk.sv
// assertions on the serial port pins of the cipher control block
`timescale 1ns/1ns
`default_nettype none
module asm_ctrl_chk (
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // sleep and serial port
  input wire logic sleep_i,
  input wire logic spi_sel_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_mosi_i,
  input wire logic spi_miso_o,
  input wire logic spi_miso_oe_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // select passes two sync flops, so every bound leaves that slack
  property p_oe_on;
    (!spi_sel_n_i && !sleep_i)[*6] |-> spi_miso_oe_o;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("data out enable missing");
  property p_oe_off;
    spi_sel_n_i[*4] |-> !spi_miso_oe_o;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("data out enable stuck");
  property p_oe_rise;
    $rose(spi_miso_oe_o) |-> $past(spi_sel_n_i, 2) == 1'b0;
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("enable rose unselected");
  property p_oe_fall;
    $fell(spi_miso_oe_o) |-> $past(spi_sel_n_i, 2) || $past(sleep_i, 3) || $past(sleep_i, 4);
  endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("enable fell while selected");
  sequence s_sclk_high;
    spi_sclk_i[*3];
  endsequence
  property p_miso_hold_hi;
    s_sclk_high |-> $stable(spi_miso_o);
  endproperty
  a_miso_hold_hi: assert property (p_miso_hold_hi) else $error("data out moved");
  property p_miso_hold_lo;
    (!spi_sclk_i && !sleep_i && !spi_sel_n_i)[*8] |-> $stable(spi_miso_o);
  endproperty
  a_miso_hold_lo: assert property (p_miso_hold_lo) else $error("data out moved idle");
  property p_sleep_clear;
    sleep_i[*5] |-> !spi_miso_oe_o && !spi_miso_o;
  endproperty
  a_sleep_clear: assert property (p_sleep_clear) else $error("pins not cleared");
  property p_sleep_enter;
    $rose(sleep_i) |-> ##[1:5] !spi_miso_oe_o;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not honoured");
  c_burst: cover property ($fell(spi_miso_oe_o));
  c_bit: cover property (s_sclk_high);
  c_sleep: cover property ($rose(sleep_i));
endmodule
bind asm_ctrl asm_ctrl_chk asm_ctrl_chk_inst (.clock_i, .rstn_i, .sleep_i, .spi_sel_n_i,
  .spi_sclk_i, .spi_mosi_i, .spi_miso_o, .spi_miso_oe_o);
`default_nettype wire

// ### tb/asm_host.sv
// host side serial master that issues sram-mode bursts
`timescale 1ns/1ns
`default_nettype none
module asm_host (
  // clock
  input wire logic clock_i,
  // serial port
  input wire logic miso_i,
  output logic sel_n_o,
  output logic sclk_o,
  output logic mosi_o
);
  initial begin
    sel_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end
  // a released data line shows the inverse of its last bit, never a kind value
  task automatic frame(input logic sel_n);
    @(negedge clock_i);
    sel_n_o = sel_n;
    if (sel_n) begin
      mosi_o = ~mosi_o;
    end
    repeat (4) @(negedge clock_i);
  endtask
  // msb first; sclk rests low, each half period four clocks
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi_o = tx[i];
      repeat (4) @(negedge clock_i);
      sclk_o = 1'b1;
      rx[i] = miso_i;
      repeat (4) @(negedge clock_i);
      sclk_o = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench of the cipher control block over its serial port
`timescale 1ns/1ns
`default_nettype none
`define check_eq(got, exp) begin cmp_count++; if ((got) !== (exp)) begin mismatches++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
  import asm_pkg::*;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic sleep_i = 1'b0;
  wire logic sel_n;
  wire logic sclk;
  wire logic mosi;
  wire logic miso;
  wire logic miso_oe;
  int mismatches = 0;
  int cmp_count = 0;
  logic [7:0] tx_b [0:19];
  logic [7:0] rx_b [0:19];
  logic [7:0] dat_b [0:15];
  logic [7:0] key_b [0:15];
  logic [7:0] junk;
  localparam logic [127:0] KAT_KEY = 128'h000102030405060708090A0B0C0D0E0F;
  localparam logic [127:0] KAT_PT = 128'h00112233445566778899AABBCCDDEEFF;
  localparam logic [127:0] KAT_CT = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
  localparam logic [127:0] KAT_RK = 128'h13111D7FE3944A17F307A78B4D2B30C5;

  always #20 clock_i = ~clock_i;

  asm_ctrl asm_ctrl_inst (.clock_i(clock_i), .rstn_i(rstn_i), .sleep_i(sleep_i),
    .spi_sel_n_i(sel_n), .spi_sclk_i(sclk), .spi_mosi_i(mosi), .spi_miso_o(miso),
    .spi_miso_oe_o(miso_oe));
  asm_host asm_host_inst (.clock_i(clock_i), .miso_i(miso), .sel_n_o(sel_n), .sclk_o(sclk),
    .mosi_o(mosi));

  task automatic burst(input logic [1:0] cmd, input logic [7:0] addr, input int n);
    asm_host_inst.frame(1'b0);
    asm_host_inst.xfer({cmd, 6'h00}, junk);
    asm_host_inst.xfer(addr, junk);
    for (int i = 0; i < n; i++) begin
      asm_host_inst.xfer(tx_b[i], rx_b[i]);
    end
    asm_host_inst.frame(1'b1);
  endtask
  task automatic put(input logic [1:0] cmd, input logic [7:0] addr, input logic [7:0] v);
    tx_b[0] = v;
    burst(cmd, addr, 1);
  endtask
  // control, sixteen window bytes, then the start byte at the mirror when n is 18
  task automatic load(input logic [7:0] ctrl, input logic [7:0] src [0:15], input int n);
    tx_b[0] = ctrl;
    for (int i = 0; i < 16; i++) begin
      tx_b[i + 1] = src[i];
    end
    tx_b[17] = ctrl | 8'h80;
    burst(CMD_SRAM_WR, ADDR_CTRL, n);
  endtask
  task automatic zeros();
    burst(CMD_SRAM_RD, ADDR_STATUS, 18);
    for (int i = 0; i < 18; i++) begin
      `check_eq(rx_b[i], 8'h00)
    end
  endtask
  function automatic logic [7:0] byte_of(input logic [127:0] v, input int i);
    return v[127 - 8 * i -: 8];
  endfunction
  task automatic win_is(input logic [127:0] v);
    burst(CMD_SRAM_RD, ADDR_WIN_LO, 16);
    for (int i = 0; i < 16; i++) begin
      `check_eq(rx_b[i], byte_of(v, i))
    end
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    junk = 8'($urandom(59));
    for (int i = 0; i < 16; i++) begin
      key_b[i] = 8'($urandom);
      dat_b[i] = 8'($urandom);
    end
    repeat (2) @(negedge clock_i);
    rstn_i = 1'b1;
    repeat (4) @(negedge clock_i);
    zeros();
    done("reset values");
    put(2'h2, ADDR_CTRL, 8'h70);
    burst(CMD_SRAM_RD, ADDR_CTRL, 1);
    `check_eq(rx_b[0], 8'h00)
    put(CMD_SRAM_WR, ADDR_CTRL, 8'h7F);
    burst(CMD_SRAM_RD, ADDR_MIRROR, 1);
    `check_eq(rx_b[0], 8'h78)
    put(CMD_SRAM_WR, ADDR_MIRROR, 8'h28);
    burst(CMD_SRAM_RD, ADDR_CTRL, 1);
    `check_eq(rx_b[0], 8'h28)
    done("control fields");
    load(8'h10, key_b, 17);
    load(8'h00, dat_b, 17);
    burst(CMD_SRAM_RD, ADDR_WIN_LO, 16);
    for (int i = 0; i < 16; i++) begin
      `check_eq(rx_b[i], dat_b[i])
    end
    put(CMD_SRAM_WR, ADDR_CTRL, 8'h10);
    burst(CMD_SRAM_RD, ADDR_WIN_LO, 16);
    for (int i = 0; i < 16; i++) begin
      `check_eq(rx_b[i], key_b[i])
    end
    tx_b[0] = 8'h00;
    for (int i = 0; i < 16; i++) begin
      tx_b[i + 1] = 8'($urandom);
    end
    burst(CMD_SRAM_WR, ADDR_CTRL, 17);
    `check_eq(rx_b[1], 8'h10)
    for (int i = 0; i < 15; i++) begin
      `check_eq(rx_b[i + 2], dat_b[i])
    end
    for (int i = 0; i < 16; i++) begin
      dat_b[i] = tx_b[i + 1];
    end
    done("window pages");
    for (int i = 0; i < 16; i++) begin
      key_b[i] = byte_of(KAT_KEY, i);
      dat_b[i] = byte_of(KAT_PT, i);
    end
    load(8'h10, key_b, 17);
    load(8'h00, dat_b, 18);
    repeat (200) @(negedge clock_i);
    burst(CMD_SRAM_RD, ADDR_STATUS, 1);
    `check_eq(rx_b[0], 8'h00)
    repeat (700) @(negedge clock_i);
    burst(CMD_SRAM_RD, ADDR_STATUS, 1);
    `check_eq(rx_b[0], 8'h01)
    burst(CMD_SRAM_RD, ADDR_MIRROR, 1);
    `check_eq(rx_b[0], 8'h00)
    win_is(KAT_CT);
    // chaining: the window holds plain xor previous result, so the same block comes out
    for (int i = 0; i < 16; i++) begin
      dat_b[i] = byte_of(KAT_PT ^ KAT_CT, i);
    end
    load(8'h20, dat_b, 18);
    repeat (700) @(negedge clock_i);
    win_is(KAT_CT);
    put(CMD_SRAM_WR, ADDR_CTRL, 8'h10);
    win_is(KAT_RK);
    for (int i = 0; i < 16; i++) begin
      key_b[i] = byte_of(KAT_RK, i);
      dat_b[i] = byte_of(KAT_CT, i);
    end
    load(8'h10, key_b, 17);
    load(8'h08, dat_b, 18);
    repeat (700) @(negedge clock_i);
    win_is(KAT_PT);
    done("runs");
    load(8'h00, dat_b, 18);
    repeat (100) @(negedge clock_i);
    burst(CMD_SRAM_RD, ADDR_STATUS, 1);
    `check_eq(rx_b[0], 8'h00)
    burst(CMD_SRAM_RD, ADDR_CTRL, 1);
    `check_eq(rx_b[0], 8'h80)
    repeat (700) @(negedge clock_i);
    burst(CMD_SRAM_RD, ADDR_STATUS, 1);
    `check_eq(rx_b[0], 8'h80)
    load(8'h00, dat_b, 18);
    repeat (700) @(negedge clock_i);
    burst(CMD_SRAM_RD, ADDR_STATUS, 1);
    `check_eq(rx_b[0], 8'h01)
    burst(CMD_SRAM_RD, ADDR_WIN_LO, 8);
    burst(CMD_SRAM_RD, ADDR_STATUS, 1);
    `check_eq(rx_b[0], 8'h81)
    put(CMD_SRAM_WR, ADDR_STATUS, 8'hFF);
    burst(CMD_SRAM_RD, ADDR_STATUS, 1);
    `check_eq(rx_b[0], 8'h81)
    done("error flag");
    sleep_i = 1'b1;
    repeat (8) @(negedge clock_i);
    sleep_i = 1'b0;
    repeat (4) @(negedge clock_i);
    zeros();
    done("sleep");
    conclude();
  end

  initial begin
    repeat (90000) @(posedge clock_i);
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
